// >>> hdl/ftp_pkg.sv
package ftp_pkg;

	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_NS       = 1000;
	localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Pulse and supply timing, in microseconds (one tick each).
	localparam int T_PULSE_US = 20;
	localparam int T_GAP_US   = 20;
	localparam int T_BLOW_US  = 100;
	localparam int T_OFF_US   = 500;
	localparam int T_ON_US    = 200;

	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] ADDR_CMD    = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_BLOWS  = 4'h8;

	localparam int CMD_CODE_LSB = 0;
	localparam int CMD_KEY_LSB  = 8;
	localparam int CMD_BLOW_BIT = 12;
	localparam int STAT_BUSY    = 0;
	localparam int STAT_REFUSED = 1;
	localparam int STAT_LOCKED  = 2;
	localparam int STAT_TRIAL   = 3;

	localparam logic [1:0] KEY_GAIN = 2'h1;
	localparam logic [1:0] KEY_QOUT = 2'h2;
	localparam logic [1:0] KEY_TEMP = 2'h3;

	localparam logic [5:0] CODE_MAX_GAIN = 6'h3f;
	localparam logic [5:0] CODE_MAX_QOUT = 6'h3f;
	localparam logic [5:0] CODE_MAX_TEMP = 6'h1f;
	localparam logic [5:0] TC_MAX        = 6'h07;
	localparam logic [5:0] WEIGHT_INVERT = 6'h08;
	localparam logic [5:0] WEIGHT_LOCK   = 6'h10;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} ftp_level_t;

	typedef struct packed {
		logic       vcc_en;
		ftp_level_t level;
	} ftp_pin_t;

	typedef struct packed {
		logic       blow;
		logic [1:0] key;
		logic [5:0] code;
	} ftp_cmd_t;

endpackage

// >>> hdl/ftp_pulse_gen.sv
`timescale 1ns/1ps
module ftp_pulse_gen import ftp_pkg::*; (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        tick,
	input  wire logic        start,
	input  wire ftp_level_t  level,
	input  wire logic [5:0]  count,
	input  wire logic [15:0] width,
	input  wire logic [15:0] gap,
	output ftp_level_t       level_out,
	output logic             done
);

	typedef enum logic [1:0] {P_IDLE, P_ON, P_OFF} ftp_pg_state_t;

	ftp_pg_state_t state;
	ftp_pg_state_t next_state;
	ftp_level_t    lvl;
	ftp_level_t    next_lvl;
	ftp_level_t    next_level_out;
	logic [5:0]    remain;
	logic [5:0]    next_remain;
	logic [15:0]   timer;
	logic [15:0]   next_timer;
	logic [15:0]   gap_q;
	logic [15:0]   next_gap_q;
	logic [15:0]   wid_q;
	logic [15:0]   next_wid_q;

	assign done = (state == P_OFF) && (timer == 16'h0000) && (remain == 6'h00);

	// Each pulse holds its level for width ticks, then low for gap ticks.
	always_comb begin
		next_state     = state;
		next_lvl       = lvl;
		next_remain    = remain;
		next_timer     = timer;
		next_gap_q     = gap_q;
		next_wid_q     = wid_q;
		next_level_out = LVL_LOW;
		unique case (state)
			P_IDLE: begin
				if (start) begin
					next_state  = P_OFF;
					next_lvl    = level;
					next_remain = count;
					next_timer  = 16'h0000;
					next_gap_q  = gap;
					next_wid_q  = width;
				end
			end
			P_ON: begin
				next_level_out = lvl;
				if (timer == 16'h0000) begin
					next_level_out = LVL_LOW;
					next_state     = P_OFF;
					next_timer     = gap_q;
				end else if (tick) begin
					next_timer = timer - 16'h0001;
				end
			end
			P_OFF: begin
				if (timer == 16'h0000) begin
					if (remain == 6'h00) begin
						next_state = P_IDLE;
					end else begin
						next_state     = P_ON;
						next_level_out = lvl;
						next_timer     = wid_q;
						next_remain    = remain - 6'h01;
					end
				end else if (tick) begin
					next_timer = timer - 16'h0001;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state     <= P_IDLE;
			lvl       <= LVL_LOW;
			remain    <= 6'h00;
			timer     <= 16'h0000;
			gap_q     <= 16'h0000;
			wid_q     <= 16'h0000;
			level_out <= LVL_LOW;
		end else begin
			state     <= next_state;
			lvl       <= next_lvl;
			remain    <= next_remain;
			timer     <= next_timer;
			gap_q     <= next_gap_q;
			wid_q     <= next_wid_q;
			level_out <= next_level_out;
		end
	end

endmodule

// >>> hdl/ftp_axil.sv
`timescale 1ns/1ps
module ftp_axil import ftp_pkg::*; (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              wvalid,
	output logic                   wready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	output logic                   bvalid,
	input  wire logic              bready,
	output logic [1:0]             bresp,
	input  wire logic              arvalid,
	output logic                   arready,
	input  wire logic [31:0]       rd_data,
	input  wire logic              rd_ok,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   wr_en,
	output logic [ADDR_W-1:0]      wr_addr,
	output logic [31:0]            wr_data,
	output logic [3:0]             wr_strb,
	input  wire logic              wr_ok
);

	logic              aw_held;
	logic              w_held;
	logic              next_aw_held;
	logic              next_w_held;
	logic [ADDR_W-1:0] next_wr_addr;
	logic [31:0]       next_wr_data;
	logic [3:0]        next_wr_strb;
	logic              next_bvalid;
	logic [1:0]        next_bresp;
	logic              next_rvalid;
	logic [31:0]       next_rdata;
	logic [1:0]        next_rresp;

	// Write takes effect once both address and data are held.
	assign wr_en = aw_held && w_held && !bvalid;

	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		next_wr_strb = wr_strb;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (awvalid && awready) begin
			next_aw_held = 1'b1;
			next_wr_addr = awaddr;
		end
		if (wvalid && wready) begin
			next_w_held  = 1'b1;
			next_wr_data = wdata;
			next_wr_strb = wstrb;
		end
		if (wr_en) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rdata  = rd_data;
			next_rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (rvalid && rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			wr_addr <= '0;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OKAY;
			awready <= 1'b0;
			wready  <= 1'b0;
			arready <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
			wr_strb <= next_wr_strb;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
			awready <= !next_aw_held && !next_bvalid;
			wready  <= !next_w_held && !next_bvalid;
			arready <= !next_rvalid;
		end
	end

endmodule

// >>> hdl/ftp_top.sv
`timescale 1ns/1ps
module ftp_top import ftp_pkg::*; #(
	parameter int PULSE_US = T_PULSE_US,
	parameter int GAP_US   = T_GAP_US,
	parameter int BLOW_US  = T_BLOW_US,
	parameter int OFF_US   = T_OFF_US,
	parameter int ON_US    = T_ON_US
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              wvalid,
	output logic                   wready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	output logic                   bvalid,
	input  wire logic              bready,
	output logic [1:0]             bresp,
	input  wire logic              arvalid,
	output logic                   arready,
	input  wire logic [ADDR_W-1:0] araddr,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output ftp_pin_t               pin
);

	localparam int TICK_W = $clog2(TICK_CYC);

	typedef enum logic [3:0] {
		S_IDLE, S_PWR_OFF, S_PWR_ON, S_ENTER, S_KEY, S_ADDR, S_CODE, S_BLOW, S_NEXT
	} ftp_state_t;

	ftp_state_t        state;
	ftp_state_t        next_state;
	ftp_cmd_t          cmd;
	ftp_cmd_t          next_cmd;
	ftp_cmd_t          cmd_in;
	ftp_pin_t          next_pin;
	ftp_level_t        pg_level;
	ftp_level_t        pg_out;
	logic [TICK_W-1:0] tick_cnt;
	logic [TICK_W-1:0] next_tick_cnt;
	logic              tick;
	logic              next_tick;
	logic [5:0]        mask;
	logic [5:0]        next_mask;
	logic [5:0]        weight;
	logic [5:0]        code_max;
	logic [5:0]        pg_count;
	logic [15:0]       pg_width;
	logic [15:0]       wait_cnt;
	logic [15:0]       next_wait_cnt;
	logic [7:0]        blows;
	logic [7:0]        next_blows;
	logic              finish;
	logic              next_finish;
	logic              locked;
	logic              next_locked;
	logic              refused;
	logic              next_refused;
	logic              launched;
	logic              next_launched;
	logic              pulse_state;
	logic              pg_start;
	logic              pg_done;
	logic              cmd_wr;
	logic              cmd_good;
	logic              wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic              wr_ok;
	logic [31:0]       rd_data;
	logic              rd_ok;

	ftp_axil u_axil (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awvalid (awvalid),
		.awready (awready),
		.awaddr  (awaddr),
		.wvalid  (wvalid),
		.wready  (wready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.bvalid  (bvalid),
		.bready  (bready),
		.bresp   (bresp),
		.arvalid (arvalid),
		.arready (arready),
		.rd_data (rd_data),
		.rd_ok   (rd_ok),
		.rvalid  (rvalid),
		.rready  (rready),
		.rdata   (rdata),
		.rresp   (rresp),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_ok   (wr_ok)
	);

	ftp_pulse_gen u_pg (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.tick      (tick),
		.start     (pg_start),
		.level     (pg_level),
		.count     (pg_count),
		.width     (pg_width),
		.gap       (16'(GAP_US)),
		.level_out (pg_out),
		.done      (pg_done)
	);

	// One microsecond tick from the bus clock.
	always_comb begin
		next_tick     = tick_cnt == TICK_W'(TICK_CYC - 1);
		next_tick_cnt = next_tick ? '0 : tick_cnt + 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			tick     <= next_tick;
		end
	end

	// Register access.
	assign wr_ok  = (wr_addr == ADDR_CMD) || (wr_addr == ADDR_STATUS);
	assign rd_ok  = (araddr == ADDR_CMD) || (araddr == ADDR_STATUS) || (araddr == ADDR_BLOWS);
	assign cmd_in = '{blow: wr_data[CMD_BLOW_BIT], key: wr_data[CMD_KEY_LSB +: 2],
		code: wr_data[CMD_CODE_LSB +: 6]};
	assign cmd_wr = wr_en && (wr_addr == ADDR_CMD);

	always_comb begin
		unique case (araddr)
			ADDR_CMD:    rd_data = {19'h0_0000, cmd.blow, 2'h0, cmd.key, 2'h0, cmd.code};
			ADDR_STATUS: rd_data = {28'h000_0000, (state == S_IDLE) && pin.vcc_en, locked, refused,
				state != S_IDLE};
			ADDR_BLOWS:  rd_data = {24'h00_0000, blows};
			default:     rd_data = 32'h0000_0000;
		endcase
	end

	// Codes above the field's top would saturate in the part, so they are refused.
	always_comb begin
		unique case (cmd_in.key)
			KEY_GAIN: code_max = CODE_MAX_GAIN;
			KEY_QOUT: code_max = CODE_MAX_QOUT;
			KEY_TEMP: code_max = CODE_MAX_TEMP;
			default:  code_max = 6'h00;
		endcase
	end

	assign cmd_good = (state == S_IDLE) && !locked && (cmd_in.key != 2'h0)
		&& (cmd_in.code <= code_max) && !(cmd_in.blow && cmd_in.code == 6'h00)
		&& (wr_strb[1:0] == 2'b11);

	// Lowest set bit still to blow; each blow addresses one weight only.
	assign weight      = mask & (~mask + 6'h01);
	assign pulse_state = (state == S_ENTER) || (state == S_KEY) || (state == S_ADDR)
		|| (state == S_CODE) || (state == S_BLOW);
	assign pg_start    = pulse_state && !launched;

	always_comb begin
		pg_level = LVL_HIGH;
		pg_count = 6'h01;
		pg_width = 16'(PULSE_US);
		unique case (state)
			S_KEY: begin
				pg_level = LVL_MID;
				pg_count = {4'h0, cmd.key};
			end
			S_CODE: begin
				pg_level = LVL_MID;
				pg_count = cmd.blow ? weight : cmd.code;
			end
			S_BLOW: pg_width = 16'(BLOW_US);
			default: pg_level = LVL_HIGH;
		endcase
	end

	always_comb begin
		next_state    = state;
		next_cmd      = cmd;
		next_mask     = mask;
		next_wait_cnt = (tick && wait_cnt != 16'h0000) ? wait_cnt - 16'h0001 : wait_cnt;
		next_blows    = blows;
		next_finish   = finish;
		next_locked   = locked;
		next_refused  = refused;
		next_launched = launched;
		next_pin      = '{vcc_en: pin.vcc_en, level: pg_out};
		if (wr_en && wr_addr == ADDR_STATUS && wr_strb[0] && wr_data[STAT_REFUSED]) begin
			next_refused = 1'b0;
		end
		if (cmd_wr && !cmd_good) begin
			next_refused = 1'b1;
		end
		if (pg_start) begin
			next_launched = 1'b1;
		end
		unique case (state)
			S_IDLE: begin
				if (cmd_wr && cmd_good) begin
					next_cmd      = cmd_in;
					next_mask     = cmd_in.blow ? cmd_in.code : 6'h00;
					next_finish   = 1'b0;
					next_wait_cnt = 16'(OFF_US);
					next_state    = S_PWR_OFF;
				end
			end
			S_PWR_OFF: begin
				// A fresh supply cycle clears all trial values in the part.
				next_pin.vcc_en = 1'b0;
				if (wait_cnt == 16'h0000) begin
					next_wait_cnt = 16'(ON_US);
					next_state    = finish ? S_IDLE : S_PWR_ON;
				end
			end
			S_PWR_ON: begin
				next_pin.vcc_en = 1'b1;
				if (wait_cnt == 16'h0000) begin
					next_state = S_ENTER;
				end
			end
			S_ENTER: if (pg_done) next_state = S_KEY;
			S_KEY:   if (pg_done) next_state = S_ADDR;
			S_ADDR:  if (pg_done) next_state = S_CODE;
			S_CODE: begin
				// Try mode stops here with power held so the trial value stays applied.
				if (pg_done) begin
					next_state = cmd.blow ? S_BLOW : S_IDLE;
				end
			end
			S_BLOW: if (pg_done) next_state = S_NEXT;
			S_NEXT: begin
				next_mask  = mask & ~weight;
				next_blows = blows + 8'h01;
				if (cmd.key == KEY_TEMP && weight == WEIGHT_LOCK) begin
					next_locked = 1'b1;
				end
				next_finish   = (mask & ~weight) == 6'h00;
				next_wait_cnt = 16'(OFF_US);
				next_state    = S_PWR_OFF;
			end
		endcase
		if (pg_done) begin
			next_launched = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state    <= S_IDLE;
			cmd      <= '0;
			mask     <= 6'h00;
			wait_cnt <= 16'h0000;
			blows    <= 8'h00;
			finish   <= 1'b0;
			locked   <= 1'b0;
			refused  <= 1'b0;
			launched <= 1'b0;
			pin      <= '{vcc_en: 1'b0, level: LVL_LOW};
		end else begin
			state    <= next_state;
			cmd      <= next_cmd;
			mask     <= next_mask;
			wait_cnt <= next_wait_cnt;
			blows    <= next_blows;
			finish   <= next_finish;
			locked   <= next_locked;
			refused  <= next_refused;
			launched <= next_launched;
			pin      <= next_pin;
		end
	end

	// Pulse counters, read only by the checks below: high pulses since the last power-up, mid pulses since the last S_ENTER or S_ADDR.
	ftp_level_t lvl_q;
	logic [3:0] hp_cnt;
	logic [5:0] mp_cnt;

	always_ff @(posedge aclk) begin
		lvl_q <= pin.level;
		if (!aresetn || !pin.vcc_en) begin
			hp_cnt <= 4'h0;
		end else if (pin.level == LVL_HIGH && lvl_q != LVL_HIGH) begin
			hp_cnt <= hp_cnt + 4'h1;
		end
		if (!aresetn || state == S_ENTER || state == S_ADDR) begin
			mp_cnt <= 6'h00;
		end else if (pin.level == LVL_MID && lvl_q != LVL_MID) begin
			mp_cnt <= mp_cnt + 6'h01;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence seq_blow_end;
		(state == S_BLOW) ##1 (state == S_NEXT);
	endsequence

	chk_enter_select: assert property ($rose(state == S_KEY) |-> hp_cnt == 4'h1)
		else $error("Selection entered without exactly one high pulse.");
	chk_enter_address: assert property ($rose(state == S_CODE) |-> hp_cnt == 4'h2)
		else $error("Addressing entered without a second high pulse.");
	chk_blow_pulse: assert property ($rose(state == S_NEXT) |-> hp_cnt == 4'h3)
		else $error("Blow finished without a third high pulse.");
	chk_no_extra_high: assert property (pin.vcc_en |-> hp_cnt <= 4'h3)
		else $error("More high pulses than one blow allows in one power cycle.");
	chk_power_cycle: assert property (seq_blow_end |-> ##[1:3] !pin.vcc_en)
		else $error("Supply not removed after a blow.");
	chk_single_weight: assert property ($rose(state == S_BLOW) |-> $onehot(mp_cnt))
		else $error("Blow addressed more than one bit weight.");
	chk_key_count: assert property ($rose(state == S_ADDR) |-> mp_cnt == {4'h0, cmd.key})
		else $error("Mid pulse count differs from the selected key.");
	chk_lock_refuse: assert property (locked |-> ##1 (state != S_PWR_OFF || $past(state) != S_IDLE))
		else $error("Programming started after lock.");

endmodule

// >>> tb/ftp_sensor_model.sv
`timescale 1ns/1ps
module ftp_sensor_model import ftp_pkg::*; (
	input wire ftp_pin_t pin
);
	int         state;
	int         key;
	logic [5:0] cnt;
	logic [5:0] fuse [1:3];
	logic [5:0] val [1:3];
	ftp_level_t prev;
	logic       locked;

	initial begin
		state = 0;
		key = 0;
		cnt = 6'h00;
		prev = LVL_LOW;
		for (int k = 1; k <= 3; k++) fuse[k] = 6'h00;
	end

	assign locked = fuse[3][4];

	// Visible value is the blown bits ORed with the trial count of the field being addressed.
	always_comb begin
		for (int k = 1; k <= 3; k++) val[k] = fuse[k] | ((state == 2 && key == k) ? cnt : 6'h00);
	end

	always @(pin) begin
		if (pin.vcc_en !== 1'b1) begin
			state = 0;
			key = 0;
			cnt = 6'h00;
		end else if (state != 3 && !locked) begin
			if (prev == LVL_MID && pin.level == LVL_LOW) begin
				if (state == 1) key = key + 1;
				else if (state == 2 && cnt < ((key == 3) ? CODE_MAX_TEMP : CODE_MAX_GAIN)) cnt = cnt + 6'h01;
			end else if (prev == LVL_HIGH && pin.level != LVL_HIGH) begin
				if (state == 2) begin
					fuse[key] = fuse[key] | cnt;
					state = 3;
				end else if (state == 0 || (key >= 1 && key <= 3)) begin
					state = state + 1;
				end
			end
		end
		prev = pin.vcc_en ? pin.level : LVL_LOW;
	end
endmodule

// >>> tb/test_fuse_trim_programming_fsm.sv
`timescale 1ns/1ps
module test_fuse_trim_programming_fsm import ftp_pkg::*;;
	logic              aclk    = 1'b0;
	logic              aresetn = 1'b0;
	logic              awvalid = 1'b0;
	logic              wvalid  = 1'b0;
	logic              bready  = 1'b0;
	logic              arvalid = 1'b0;
	logic              rready  = 1'b0;
	logic [ADDR_W-1:0] awaddr  = '0;
	logic [ADDR_W-1:0] araddr  = '0;
	logic [31:0]       wdata   = 32'h0;
	logic [3:0]        wstrb   = 4'h0;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp;
	logic [31:0]       rdata;
	logic [31:0]       d;
	logic [31:0]       bad [0:2];
	ftp_pin_t          pin;
	int                n_errors = 0;
	int                n_checks = 0;

	always #4 aclk = ~aclk;

	ftp_top #(.PULSE_US(2), .GAP_US(2), .BLOW_US(3), .OFF_US(4), .ON_US(3)) dut (
		.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .pin(pin)
	);

	ftp_sensor_model dev (
		.pin(pin)
	);

	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!(awvalid === 1'b0 || awready) || !(wvalid === 1'b0 || wready));
		while (bvalid !== 1'b1) @(posedge aclk);
		chk({30'h0, bresp}, {30'h0, er});
		bready <= 1'b0;
	endtask

	task automatic axr(input logic [ADDR_W-1:0] a, output logic [1:0] r);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [1:0] r;
		axr(a, r);
		chk(d, ed);
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic run(input logic [1:0] k, input logic [5:0] c, input logic b);
		logic [1:0] r;
		axw(ADDR_CMD, {19'h0, b, 2'h0, k, 2'h0, c}, RESP_OKAY);
		do axr(ADDR_STATUS, r); while (d[STAT_BUSY] !== 1'b0);
	endtask

	function automatic logic [31:0] w6(input logic [5:0] v);
		return {26'h0, v};
	endfunction

	initial begin
		repeat (80000) @(posedge aclk);
		n_errors++;
		summarize();
	end

	initial begin
		bad[0] = 32'h0000_0001;
		bad[1] = 32'h0000_0320;
		bad[2] = 32'h0000_1100;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd_chk(ADDR_STATUS, 32'h0, RESP_OKAY);
		rd_chk(4'hc, 32'h0, RESP_SLVERR);
		axw(ADDR_BLOWS, 32'h1, RESP_SLVERR);
		$display("test registers done");

		run(KEY_GAIN, 6'h03, 1'b0);
		chk(w6(dev.val[1]), 32'h3);
		chk(w6(dev.fuse[1]), 32'h0);
		chk(32'(dev.state), 32'h2);
		rd_chk(ADDR_STATUS, 32'h8, RESP_OKAY);
		rd_chk(ADDR_CMD, 32'h0000_0103, RESP_OKAY);
		run(KEY_QOUT, 6'h04, 1'b0);
		chk(w6(dev.val[2]), 32'h4);
		chk(w6(dev.val[1]), 32'h0);
		$display("test try done");

		run(KEY_GAIN, 6'h05, 1'b1);
		chk(w6(dev.fuse[1]), 32'h5);
		chk(32'(dev.state), 32'h0);
		rd_chk(ADDR_BLOWS, 32'h2, RESP_OKAY);
		run(KEY_TEMP, WEIGHT_INVERT, 1'b1);
		chk(w6(dev.fuse[3]), w6(WEIGHT_INVERT));
		run(KEY_TEMP, TC_MAX, 1'b0);
		chk(w6(dev.val[3]), w6(WEIGHT_INVERT | TC_MAX));
		chk(w6(dev.val[1]), 32'h5);
		$display("test blow done");

		for (int i = 0; i < 3; i++) begin
			axw(ADDR_CMD, bad[i], RESP_OKAY);
			rd_chk(ADDR_STATUS, 32'ha, RESP_OKAY);
			axw(ADDR_STATUS, 32'h2, RESP_OKAY);
			rd_chk(ADDR_STATUS, 32'h8, RESP_OKAY);
		end
		chk(w6(dev.val[3]), w6(WEIGHT_INVERT | TC_MAX));
		$display("test refusal done");

		run(KEY_TEMP, WEIGHT_LOCK, 1'b1);
		chk(w6(dev.fuse[3]), w6(WEIGHT_INVERT | WEIGHT_LOCK));
		rd_chk(ADDR_STATUS, 32'h4, RESP_OKAY);
		axw(ADDR_CMD, 32'h0000_0101, RESP_OKAY);
		rd_chk(ADDR_STATUS, 32'h6, RESP_OKAY);
		rd_chk(ADDR_BLOWS, 32'h4, RESP_OKAY);
		chk(w6(dev.val[1]), 32'h5);
		$display("test lock done");
		summarize();
	end
endmodule
